// *** logic/gmfe_front_end.sv ***
// Purpose: listener/talker message front end, splits and dispatches commands
// Assumes: bus bytes arrive as same-clock strobes from the acceptor handshake
// Notes:   command meaning is left to the executor behind the cmd_* port
`default_nettype none
module gmfe_front_end
	import gmfe_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH,
	parameter int AW    = BUF_AW
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic [4:0] addr_sw,
	input  wire logic       term_lf_sw,
	input  wire logic       addr_reload,
	input  wire logic       ren_n,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_atn,
	input  wire logic       rx_eoi,
	output logic            rx_ready,
	output logic            cmd_valid,
	output logic [7:0]      cmd_data,
	output logic            cmd_end,
	output logic            cmd_query,
	output logic            cmd_refused,
	input  wire logic       cmd_ready,
	input  wire logic       resp_valid,
	input  wire logic [7:0] resp_data,
	input  wire logic       resp_last,
	output logic            resp_ready,
	input  wire logic       tx_req,
	output logic            tx_valid,
	output logic [7:0]      tx_data,
	output logic            tx_eoi,
	input  wire logic       err_valid,
	input  wire logic [7:0] err_code,
	input  wire logic       event_ack,
	output logic [7:0]      event_code,
	output logic            srq_o,
	output logic            srq_oe,
	output logic            listen,
	output logic            talk,
	output logic            remote,
	output logic            dev_clear
);
	// two-flop synchronisers for pins; no reset, so the first edge
	// after release already sees settled switches, not a zero address
	logic [7:0] pin_s1_reg;
	logic [7:0] pin_s2_reg;
	always_ff @(posedge mclk) begin
		pin_s1_reg <= {ren_n, addr_reload, term_lf_sw, addr_sw};
		pin_s2_reg <= pin_s1_reg;
	end
	wire logic       ren_on  = !pin_s2_reg[7];
	wire logic       reload  = pin_s2_reg[6];
	wire logic       term_lf = pin_s2_reg[5];

	// address caught after reset release and on reload, never under the reset
	logic [4:0] addr_reg;
	logic       loaded_reg;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addr_reg   <= ADDR_RESET;
			loaded_reg <= 1'b0;
		end else begin
			loaded_reg <= 1'b1;
			if (!loaded_reg || reload) begin
				addr_reg <= pin_s2_reg[4:0];
			end
		end
	end

	function automatic logic is_blank(input logic [7:0] c);
		is_blank = (c == CH_SPACE) || (c == CH_CR) || (c == CH_LF);
	endfunction : is_blank

	// interface messages
	wire logic atn_byte = rx_valid && rx_atn;
	wire logic on_bus   = (addr_reg != ADDR_OFF_BUS);
	wire logic my_la    = on_bus && (rx_data == (LISTEN_BASE | {3'b000, addr_reg}));
	wire logic my_ta    = on_bus && (rx_data == (TALK_BASE | {3'b000, addr_reg}));
	wire logic clr_hit  = atn_byte && ((rx_data == CODE_DCL) ||
		(listen && rx_data == CODE_SDC));
	logic spoll_reg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			listen    <= 1'b0;
			talk      <= 1'b0;
			spoll_reg <= 1'b0;
		end else if (atn_byte) begin
			// unlisten/untalk only take effect if sent; none is required
			if (my_la) begin
				listen <= 1'b1;
				talk   <= 1'b0;
			end else if (my_ta) begin
				talk   <= 1'b1;
				listen <= 1'b0;
			end else if (rx_data == CODE_UNL) begin
				listen <= 1'b0;
			end else if (rx_data == CODE_UNT) begin
				talk   <= 1'b0;
			end
			if (rx_data == CODE_SPE) begin
				spoll_reg <= 1'b1;
			end else if (rx_data == CODE_SPD) begin
				spoll_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			remote <= 1'b0;
		end else if (!ren_on) begin
			remote <= 1'b0;
		end else if (atn_byte && listen && rx_data == CODE_GTL) begin
			remote <= 1'b0;
		end else if (atn_byte && my_la) begin
			remote <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dev_clear <= 1'b0;
		end else begin
			dev_clear <= clr_hit;
		end
	end

	// message capture and parse
	gmfe_mem_if #(.AW(AW)) mem ();
	gmfe_msg_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
		.mclk (mclk),
		.mem  (mem)
	);

	gmfe_state_t state_reg;
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0]   len_reg;
	logic          have_cmd_reg;
	logic          head_reg;
	logic          query_reg;
	logic          ovf_pulse;

	// new data bytes are held off while a message is being dispatched; ATN bytes still pass
	assign rx_ready = rx_atn || (state_reg == GMFE_RECV);
	wire logic data_in  = rx_valid && !rx_atn && listen && (state_reg == GMFE_RECV);
	wire logic term_hit = rx_eoi || (term_lf && rx_data == CH_LF);
	wire logic buf_full = (wr_ptr_reg == AW'(DEPTH - 1));
	wire logic [7:0] cur = mem.rd_data;
	wire logic at_end   = ({1'b0, rd_ptr_reg} == len_reg);
	wire logic emit_end = (state_reg == GMFE_EMIT) && (at_end || cur == CH_SEMI) && have_cmd_reg;
	wire logic emit_dat = (state_reg == GMFE_EMIT) && !at_end && cur != CH_SEMI &&
		!(is_blank(cur) && !have_cmd_reg) && cur != CH_CR && cur != CH_LF;

	assign mem.wr_en   = data_in && !buf_full;
	assign mem.wr_addr = wr_ptr_reg;
	assign mem.wr_data = rx_data;
	assign mem.rd_addr = rd_ptr_reg;
	assign ovf_pulse   = data_in && buf_full;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_reg  <= GMFE_RECV;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			len_reg    <= '0;
		end else if (clr_hit) begin
			state_reg  <= GMFE_RECV;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			case (state_reg)
				GMFE_RECV: begin
					if (data_in) begin
						if (!buf_full) begin
							wr_ptr_reg <= wr_ptr_reg + 1'b1;
						end
						if (term_hit) begin
							len_reg    <= {1'b0, wr_ptr_reg} + {{AW{1'b0}}, !buf_full};
							rd_ptr_reg <= '0;
							state_reg  <= GMFE_FETCH;
						end
					end
				end
				GMFE_FETCH: begin
					state_reg <= GMFE_EMIT;
				end
				GMFE_EMIT: begin
					if (emit_end || emit_dat) begin
						if (cmd_ready && at_end) begin
							state_reg  <= GMFE_RECV;
							wr_ptr_reg <= '0;
						end else if (cmd_ready) begin
							rd_ptr_reg <= rd_ptr_reg + 1'b1;
							state_reg  <= GMFE_FETCH;
						end
					end else if (at_end) begin
						state_reg  <= GMFE_RECV;
						wr_ptr_reg <= '0;
					end else begin
						rd_ptr_reg <= rd_ptr_reg + 1'b1;
						state_reg  <= GMFE_FETCH;
					end
				end
				default: begin
					state_reg <= GMFE_RECV;
				end
			endcase
		end
	end

	// per-command tracking; a separator closes one command before the next opens
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			have_cmd_reg <= 1'b0;
			head_reg     <= 1'b1;
			query_reg    <= 1'b0;
		end else if (clr_hit || (emit_end && cmd_ready)) begin
			have_cmd_reg <= 1'b0;
			head_reg     <= 1'b1;
			query_reg    <= 1'b0;
		end else if (emit_dat && cmd_ready) begin
			have_cmd_reg <= 1'b1;
			if (cur == CH_SPACE || cur == CH_COLON) begin
				head_reg <= 1'b0;
			end
			if (head_reg && cur == CH_QUERY) begin
				query_reg <= 1'b1;
			end
		end
	end

	// queries pass regardless; setting commands need remote
	wire logic refuse = emit_end && !query_reg && !remote;
	assign cmd_valid   = emit_end || emit_dat;
	assign cmd_data    = emit_dat ? cur : 8'h00;
	assign cmd_end     = emit_end;
	assign cmd_query   = emit_end && query_reg;
	assign cmd_refused = refuse;

	// service request and event code
	logic rqs_reg;
	wire logic fault = (refuse && cmd_ready) || ovf_pulse || err_valid;
	wire logic [7:0] fault_code = err_valid ? err_code :
		(ovf_pulse ? EV_OVERFLOW : EV_NOT_REMOTE);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			event_code <= EV_NONE;
		end else if (fault) begin
			event_code <= fault_code; // set wins over ack
		end else if (event_ack || clr_hit) begin
			event_code <= EV_NONE;
		end
	end

	// polled status byte taken on the clock that sends it
	wire logic tx_go = tx_req && talk;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rqs_reg <= 1'b0;
		end else if (fault) begin
			rqs_reg <= 1'b1;
		end else if ((tx_go && spoll_reg) || clr_hit) begin
			rqs_reg <= 1'b0;
		end
	end
	assign srq_o  = 1'b0;
	assign srq_oe = rqs_reg;

	// talker: answers held by the executor until the device is talked
	assign resp_ready = tx_go && !spoll_reg && resp_valid;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_eoi   <= 1'b0;
		end else begin
			tx_valid <= tx_go;
			if (tx_go) begin
				if (spoll_reg) begin
					tx_data <= {1'b0, rqs_reg, 6'h00} | {4'h0, event_code[3:0]};
					tx_eoi  <= 1'b0;
				end else if (resp_valid) begin
					tx_data <= resp_data;
					tx_eoi  <= resp_last;
				end else begin
					tx_data <= NOTHING_BYTE;
					tx_eoi  <= 1'b1;
				end
			end
		end
	end
endmodule : gmfe_front_end
`default_nettype wire

// *** shared/gmfe_pkg.sv ***
// Purpose: constants and types shared by the message front end, its checks and its bench
// Assumes: 25 MHz mclk, bus bytes already handshaken into the mclk domain
// Notes:   bus codes are the standard interface message codes
`default_nettype none
package gmfe_pkg;
	localparam logic [7:0] LISTEN_BASE  = 8'h20;
	localparam logic [7:0] TALK_BASE    = 8'h40;
	localparam logic [7:0] CODE_UNL     = 8'h3f;
	localparam logic [7:0] CODE_UNT     = 8'h5f;
	localparam logic [7:0] CODE_DCL     = 8'h14;
	localparam logic [7:0] CODE_SDC     = 8'h04;
	localparam logic [7:0] CODE_GTL     = 8'h01;
	localparam logic [7:0] CODE_SPE     = 8'h18;
	localparam logic [7:0] CODE_SPD     = 8'h19;
	localparam logic [4:0] ADDR_OFF_BUS = 5'h1f;
	localparam logic [4:0] ADDR_RESET   = 5'h1f;
	localparam logic [7:0] CH_SEMI      = 8'h3b;
	localparam logic [7:0] CH_QUERY     = 8'h3f;
	localparam logic [7:0] CH_LF        = 8'h0a;
	localparam logic [7:0] CH_CR        = 8'h0d;
	localparam logic [7:0] CH_SPACE     = 8'h20;
	localparam logic [7:0] CH_COLON     = 8'h3a;
	localparam logic [7:0] NOTHING_BYTE = 8'hff;
	localparam logic [7:0] EV_NONE      = 8'h00;
	localparam logic [7:0] EV_NOT_REMOTE = 8'h66;
	localparam logic [7:0] EV_OVERFLOW  = 8'h67;
	localparam int         STB_RQS_BIT  = 6;
	localparam int         BUF_DEPTH    = 256;
	localparam int         BUF_AW       = 8;

	typedef enum logic [1:0] {
		GMFE_RECV  = 2'b00,
		GMFE_FETCH = 2'b01,
		GMFE_EMIT  = 2'b10
	} gmfe_state_t;
endpackage : gmfe_pkg
`default_nettype wire

// *** shared/gmfe_mem_if.sv ***
// Purpose: carrier between the front end and its message byte store
// Assumes: one write port, one registered read port
// Notes:   read data is valid one cycle after rd_addr
`default_nettype none
interface gmfe_mem_if #(parameter int AW = 8);
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0]    wr_data;
	logic [AW-1:0] rd_addr;
	logic [7:0]    rd_data;

	modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
		input rd_data);
	modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
		output rd_data);
endinterface : gmfe_mem_if
`default_nettype wire

// *** logic/gmfe_msg_store.sv ***
// Purpose: byte store holding one incoming message until it is parsed
// Assumes: single clock, no reset on the array
// Notes:   read data comes out of a register
`default_nettype none
module gmfe_msg_store #(
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic mclk,
	gmfe_mem_if.store mem
);
	logic [7:0] arr [DEPTH];

	always_ff @(posedge mclk) begin
		if (mem.wr_en) begin
			arr[mem.wr_addr] <= mem.wr_data;
		end
		mem.rd_data <= arr[mem.rd_addr];
	end
endmodule : gmfe_msg_store
`default_nettype wire

// *** test/gmfe_front_end_properties.sv ***
// Purpose: port checks of the message front end
// Assumes: one clock, async active-low reset
// Notes:   bound onto every front end instance
`default_nettype none
module gmfe_front_end_properties
	import gmfe_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       ren_n,
	input wire logic       rx_atn,
	input wire logic       rx_ready,
	input wire logic       tx_req,
	input wire logic       tx_valid,
	input wire logic       talk,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic       cmd_end,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_query,
	input wire logic       cmd_refused,
	input wire logic       remote,
	input wire logic       srq_oe,
	input wire logic [7:0] event_code,
	input wire logic       err_valid,
	input wire logic [7:0] err_code
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_rx_holdoff: assert property (cmd_valid && !rx_atn |-> !rx_ready)
		else $error("data taken while dispatching");
	chk_tx_prompt: assert property (tx_req && talk |=> tx_valid)
		else $error("talker byte missing");
	chk_tx_cause: assert property (tx_valid |-> $past(tx_req) && $past(talk))
		else $error("talker byte without request");
	chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
		else $error("command beat not held");
	chk_end_empty: assert property (cmd_valid && cmd_end |-> cmd_data == 8'h00)
		else $error("end beat carries data");
	chk_refuse_local: assert property (cmd_valid && cmd_end && cmd_refused |-> !remote)
		else $error("refused while remote");
	chk_query_free: assert property (cmd_valid && cmd_end && cmd_query |-> !cmd_refused)
		else $error("query refused");
	chk_refuse_event: assert property (cmd_valid && cmd_ready && cmd_end && cmd_refused
		&& !err_valid |=> event_code == EV_NOT_REMOTE ##[0:2] srq_oe)
		else $error("refusal not reported");
	chk_err_event: assert property (err_valid |=> event_code == $past(err_code))
		else $error("error code not held");
	chk_ren_drop: assert property ($rose(ren_n) |-> ##[0:4] !remote)
		else $error("remote kept without enable");
endmodule : gmfe_front_end_properties
bind gmfe_front_end gmfe_front_end_properties i_chk (.mclk, .rstn, .ren_n, .rx_atn, .rx_ready,
	.tx_req, .tx_valid, .talk, .cmd_valid, .cmd_ready, .cmd_end, .cmd_data, .cmd_query,
	.cmd_refused, .remote, .srq_oe, .event_code, .err_valid, .err_code);
`default_nettype wire

// *** test/gmfe_ctrl_model.sv ***
// Purpose: bus controller stand-in
// Assumes: strobes change on the falling edge
// Notes:   idle data shows the inverse of the last byte
`default_nettype none
module gmfe_ctrl_model (
	input  wire logic       mclk,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_eoi,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_atn,
	output logic            rx_eoi,
	output logic            tx_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_atn = 1'b0;
		rx_eoi = 1'b0;
		tx_req = 1'b0;
	end
	// data waits for the receive state, a byte sent while parsing is lost
	task put(input logic atn, input logic eoi, input logic [7:0] b);
		@(negedge mclk);
		for (int i = 0; i < 64 && !atn && rx_ready !== 1'b1; i++) begin
			@(negedge mclk);
		end
		rx_valid = 1'b1;
		rx_atn = atn;
		rx_eoi = eoi;
		rx_data = b;
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_atn = 1'b0;
		rx_eoi = 1'b0;
		rx_data = ~b;
	endtask : put
	task get(output logic [7:0] d, output logic e, output logic ok);
		@(negedge mclk);
		tx_req = 1'b1;
		@(negedge mclk);
		tx_req = 1'b0;
		ok = 1'b0;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (tx_valid === 1'b1) begin
				ok = 1'b1;
				d = tx_data;
				e = tx_eoi;
			end else begin
				@(negedge mclk);
			end
		end
	endtask : get
endmodule : gmfe_ctrl_model
`default_nettype wire

// *** test/tb_gmfe_front_end.sv ***
// Purpose: self-checking bench of the message front end
// Assumes: bench drives on the falling edge
// Notes:   executor side is played by the bench
`default_nettype none
module tb_gmfe_front_end;
	import gmfe_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] ADDR = 5'h05;
	logic mclk, rstn, term_lf_sw, addr_reload, ren_n, rx_valid, rx_atn, rx_eoi, rx_ready;
	logic cmd_valid, cmd_end, cmd_query, cmd_refused, cmd_ready, resp_valid, resp_last;
	logic resp_ready, tx_req, tx_valid, tx_eoi, err_valid, event_ack, srq_o, srq_oe;
	logic listen, talk, remote, dev_clear, e, ok;
	logic [4:0] addr_sw;
	logic [7:0] rx_data, cmd_data, resp_data, tx_data, err_code, event_code, d, first;
	logic [1:0] ends[$];
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	gmfe_front_end i_dut (.mclk, .rstn, .addr_sw, .term_lf_sw, .addr_reload, .ren_n,
		.rx_valid, .rx_data, .rx_atn, .rx_eoi, .rx_ready, .cmd_valid, .cmd_data, .cmd_end,
		.cmd_query, .cmd_refused, .cmd_ready, .resp_valid, .resp_data, .resp_last,
		.resp_ready, .tx_req, .tx_valid, .tx_data, .tx_eoi, .err_valid, .err_code,
		.event_ack, .event_code, .srq_o, .srq_oe, .listen, .talk, .remote, .dev_clear);
	gmfe_ctrl_model cm (.mclk, .rx_ready, .tx_valid, .tx_data, .tx_eoi, .rx_valid,
		.rx_data, .rx_atn, .rx_eoi, .tx_req);
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task collect(input int n);
		ends.delete();
		first = 8'h00;
		for (int i = 0; i < 200 && ends.size() < n; i++) begin
			@(negedge mclk);
			cmd_ready = 1'b1;
			if (cmd_valid === 1'b1 && cmd_end === 1'b1)
				ends.push_back({cmd_query, cmd_refused});
			else if (cmd_valid === 1'b1 && first === 8'h00)
				first = cmd_data;
		end
		chk("ends", 8'(ends.size()), 8'(n));
	endtask : collect
	task t_split;
		ren_n = 1'b0;
		repeat (3) @(negedge mclk);
		cm.put(1'b1, 1'b0, LISTEN_BASE + {3'h0, ADDR});
		chk("listen", {7'h0, listen}, 8'h01);
		chk("remote", {7'h0, remote}, 8'h01);
		cm.put(1'b0, 1'b0, 8'h41);
		cm.put(1'b0, 1'b0, CH_SEMI);
		cm.put(1'b0, 1'b0, 8'h42);
		cm.put(1'b0, 1'b1, CH_QUERY);
		collect(2);
		chk("first", first, 8'h41);
		chk("end0", {6'h0, ends[0]}, 8'h00);
		chk("end1", {6'h0, ends[1]}, 8'h02);
		cm.put(1'b1, 1'b0, TALK_BASE + {3'h0, ADDR});
		resp_valid = 1'b1;
		resp_data = 8'h58;
		resp_last = 1'b1;
		cm.get(d, e, ok);
		resp_valid = 1'b0;
		chk("answer", ok ? d : 8'h00, 8'h58);
		cm.get(d, e, ok);
		chk("idle", ok ? d : 8'h00, NOTHING_BYTE);
		chk("idle eoi", {7'h0, e}, 8'h01);
		$display("test split done");
	endtask : t_split
	task t_refuse;
		ren_n = 1'b1;
		repeat (6) @(negedge mclk);
		chk("local", {7'h0, remote}, 8'h00);
		cmd_ready = 1'b0;
		cm.put(1'b1, 1'b0, LISTEN_BASE + {3'h0, ADDR});
		cm.put(1'b0, 1'b1, 8'h43);
		repeat (4) @(negedge mclk);
		collect(1);
		chk("held", first, 8'h43);
		chk("refused", {6'h0, ends[0]}, 8'h01);
		repeat (3) @(negedge mclk);
		chk("srq", {7'h0, srq_oe}, 8'h01);
		chk("event", event_code, EV_NOT_REMOTE);
		cm.put(1'b1, 1'b0, CODE_SPE);
		cm.put(1'b1, 1'b0, TALK_BASE + {3'h0, ADDR});
		cm.get(d, e, ok);
		chk("status", ok ? d : 8'h00, {4'h4, EV_NOT_REMOTE[3:0]});
		cm.put(1'b1, 1'b0, CODE_SPD);
		event_ack = 1'b1;
		@(negedge mclk);
		event_ack = 1'b0;
		repeat (2) @(negedge mclk);
		chk("acked", event_code, EV_NONE);
		chk("srq off", {7'h0, srq_oe}, 8'h00);
		err_valid = 1'b1;
		err_code = 8'h2a;
		@(negedge mclk);
		err_valid = 1'b0;
		chk("err", event_code, 8'h2a);
		cm.put(1'b1, 1'b0, CODE_DCL);
		chk("dcl pulse", {7'h0, dev_clear}, 8'h01);
		repeat (3) @(negedge mclk);
		chk("cleared", event_code, EV_NONE);
		chk("clr srq", {7'h0, srq_oe}, 8'h00);
		$display("test refuse done");
	endtask : t_refuse
	task t_local;
		term_lf_sw = 1'b1;
		ren_n = 1'b0;
		repeat (3) @(negedge mclk);
		cm.put(1'b1, 1'b0, LISTEN_BASE + {3'h0, ADDR});
		cm.put(1'b0, 1'b0, CH_SPACE);
		cm.put(1'b0, 1'b0, 8'h53);
		cm.put(1'b0, 1'b0, CH_LF);
		collect(1);
		chk("lf first", first, 8'h53);
		chk("lf end", {6'h0, ends[0]}, 8'h00);
		cm.put(1'b1, 1'b0, CODE_GTL);
		chk("to local", {7'h0, remote}, 8'h00);
		for (int i = 0; i < 256; i++) begin
			cm.put(1'b0, 1'b0, 8'h41);
		end
		chk("overflow", event_code, EV_OVERFLOW);
		chk("ovf srq", {7'h0, srq_oe}, 8'h01);
		chk("srq pin", {7'h0, srq_o}, 8'h00);
		cm.put(1'b1, 1'b0, CODE_SDC);
		chk("sdc pulse", {7'h0, dev_clear}, 8'h01);
		repeat (2) @(negedge mclk);
		chk("sdc clear", event_code, EV_NONE);
		term_lf_sw = 1'b0;
		$display("test local done");
	endtask : t_local
	task t_offbus;
		cm.put(1'b1, 1'b0, CODE_UNL);
		cm.put(1'b1, 1'b0, CODE_UNT);
		addr_sw = ADDR_OFF_BUS;
		addr_reload = 1'b1;
		repeat (4) @(negedge mclk);
		addr_reload = 1'b0;
		cm.put(1'b1, 1'b0, LISTEN_BASE + {3'h0, ADDR});
		chk("off listen", {7'h0, listen}, 8'h00);
		cm.put(1'b1, 1'b0, LISTEN_BASE + {3'h0, ADDR_OFF_BUS});
		chk("off listen 31", {7'h0, listen}, 8'h00);
		cm.put(1'b1, 1'b0, TALK_BASE + {3'h0, ADDR_OFF_BUS});
		chk("off talk", {7'h0, talk}, 8'h00);
		$display("test offbus done");
	endtask : t_offbus
	task conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial begin
		rstn = 1'b0;
		addr_sw = ADDR;
		term_lf_sw = 1'b0;
		addr_reload = 1'b0;
		ren_n = 1'b1;
		cmd_ready = 1'b1;
		resp_valid = 1'b0;
		resp_data = 8'h00;
		resp_last = 1'b0;
		err_valid = 1'b0;
		err_code = 8'h00;
		event_ack = 1'b0;
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		repeat (4) @(negedge mclk);
		t_split();
		t_refuse();
		t_local();
		t_offbus();
		conclude();
	end
endmodule : tb_gmfe_front_end
`default_nettype wire
